// >>> core/error_flag_ctrl.sv
`timescale 1ns/10ps
`include "rxerr_cfg.svh"
module error_flag_ctrl #(
  parameter int GP_DIV = `GP_DIV_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Host serial port
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        ser_enable,
  // Receiver status
  input  wire logic        pll_locked,
  input  wire logic        block_start,
  input  wire logic        subframe_strobe,
  input  wire logic        parity_error,
  input  wire logic        non_pcm_detected,
  input  wire logic        rate_change_meas,
  input  wire logic        rate_change_cs,
  input  wire logic        osc_stopped,
  // Block data for update flags
  input  wire logic        block_valid,
  input  wire logic [47:0] cs_bits,
  input  wire logic [15:0] burst_pc,
  // General-purpose parallel input
  input  wire logic        gp_parallel_in_mode,
  input  wire logic [3:0]  gp_in,
  // Input detection
  input  wire logic        input_detect_report_en,
  input  wire logic        crystal_input_select,
  input  wire logic        crystal_24m576_present,
  input  wire logic        input_monitor_en,
  input  wire logic        input_change,
  // Outputs
  output logic             error_flag_pin,
  output logic             audio_out_en,
  output logic             audio_mute,
  output logic             cs_updated,
  output logic             pc_updated,
  output logic             gp_updated,
  output logic             input_detect_report,
  output logic [7:0]       error_output_settings
);
  rxerr_pkg::ctrl_state_type s_q, s_d;
  wait_if w ();

  // Settings fields
  logic       sel;
  logic       par_mode;
  logic       force_hi;
  logic       rate_mask;
  logic [1:0] wait_code;
  // Error sources
  logic       rate_chg;
  logic       rate_err;
  logic       par_recent;
  logic       data_err;
  logic       npcm_err;
  logic       err_now;
  logic       wait_busy;
  // Serial port events
  logic       ser_rise;
  logic       ser_start;
  logic       ser_fall_ce;
  logic       addr_ok;
  logic       len_ok;
  logic       cmd_ok;
  logic       write_ok;
  // Update sources
  logic       gp_tick;
  logic       detect_gate;

  assign sel       = s_q.settings[`SET_SEL_BIT];
  assign par_mode  = s_q.settings[`SET_PAR_BIT];
  assign force_hi  = s_q.settings[`SET_FORCE_BIT];
  assign rate_mask = s_q.settings[`SET_MASK_BIT];
  assign wait_code = s_q.settings[`SET_WAIT_LO +: 2];

  // Block preamble wait after lock
  preamble_counter u_wait (
    .mclk  (mclk),
    .rst_b (rst_b),
    .w     (w.cnt)
  );

  always_comb begin
    case (wait_code)
      2'h0:    w.target = `WAIT_CODE0;
      2'h1:    w.target = `WAIT_CODE1;
      2'h2:    w.target = `WAIT_CODE2;
      default: w.target = `WAIT_CODE3;
    endcase
  end
  assign w.clear   = !pll_locked;
  assign w.tick    = block_start;
  assign wait_busy = !w.done;

  // Rate change source
  always_comb begin
    if (osc_stopped) begin
      rate_chg = rate_change_cs;
    end else begin
      rate_chg = rate_change_meas || rate_change_cs;
    end
    rate_err = !rate_mask && rate_chg;
  end

  // Parity data error
  assign par_recent = (s_q.par_run != 4'h0);
  always_comb begin
    if (par_mode) begin
      data_err = parity_error && subframe_strobe;
    end else begin
      data_err = par_recent && non_pcm_detected;
    end
  end

  // Errors seen this cycle
  assign npcm_err = sel && non_pcm_detected;
  assign err_now  = !pll_locked || data_err || npcm_err || rate_err;

  // Serial port events
  assign ser_rise    = ser_clk && !s_q.clk;
  assign ser_start   = ser_enable && !s_q.ce;
  assign ser_fall_ce = !ser_enable && s_q.ce;
  assign addr_ok     = (s_q.addr == `SER_DEV_ADDR);
  assign len_ok      = (s_q.nbits == 5'h10);
  assign cmd_ok      = (s_q.data[7:4] == `SER_CMD_ERR) && (s_q.data[3:2] == 2'h0);
  assign write_ok    = ser_fall_ce && addr_ok && len_ok && cmd_ok;

  // Update sources
  assign gp_tick     = (s_q.gp_div == 13'(GP_DIV - 1));
  assign detect_gate = input_detect_report_en && crystal_input_select &&
                       crystal_24m576_present && input_monitor_en;

  always_comb begin
    s_d     = s_q;
    s_d.ce  = ser_enable;
    s_d.clk = ser_clk;

    // Serial settings write
    if (ser_start) begin
      s_d.phase = rxerr_pkg::PH_DATA;
      s_d.nbits = 5'h00;
    end
    if (ser_rise) begin
      case (s_q.phase)
        rxerr_pkg::PH_ADDR: begin
          s_d.addr = {ser_data, s_q.addr[7:1]};
        end
        rxerr_pkg::PH_DATA: begin
          if (!len_ok) begin
            s_d.data  = {ser_data, s_q.data[15:1]};
            s_d.nbits = s_q.nbits + 5'h01;
          end
        end
        default: begin
          s_d.phase = rxerr_pkg::PH_ADDR;
        end
      endcase
    end
    if (ser_fall_ce) begin
      s_d.phase = rxerr_pkg::PH_ADDR;
    end
    if (write_ok) begin
      s_d.settings = s_q.data[15:8] & `SET_USED_MASK;
    end

    // Parity error run over 8 sub-frames
    if (subframe_strobe) begin
      if (parity_error) begin
        s_d.par_run = `PAR_RUN;
      end else if (par_recent) begin
        s_d.par_run = s_q.par_run - 4'h1;
      end
    end

    // Error pin, mute and audio enable
    s_d.err_pin  = force_hi || err_now || wait_busy;
    s_d.mute     = npcm_err;
    s_d.audio_en = !err_now && !wait_busy && !npcm_err;

    // Block update flags
    s_d.cs_upd = 1'h0;
    s_d.pc_upd = 1'h0;
    if (block_valid) begin
      s_d.cs_upd  = (cs_bits == s_q.cs_prev);
      s_d.pc_upd  = (burst_pc == s_q.pc_prev);
      s_d.cs_prev = cs_bits;
      s_d.pc_prev = burst_pc;
    end

    // General-purpose input sampled at 24kHz
    s_d.gp_upd = 1'h0;
    if (gp_tick) begin
      s_d.gp_div  = 13'h0000;
      s_d.gp_prev = gp_in;
      s_d.gp_upd  = gp_parallel_in_mode && (gp_in != s_q.gp_prev);
    end else begin
      s_d.gp_div = s_q.gp_div + 13'h0001;
    end

    // Input detection report
    s_d.detect_rep = detect_gate && input_change;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_q          <= '0;
      s_q.settings <= `SET_RESET;
      s_q.err_pin  <= 1'h1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops
  assign error_flag_pin        = s_q.err_pin;
  assign audio_out_en          = s_q.audio_en;
  assign audio_mute            = s_q.mute;
  assign cs_updated            = s_q.cs_upd;
  assign pc_updated            = s_q.pc_upd;
  assign gp_updated            = s_q.gp_upd;
  assign input_detect_report   = s_q.detect_rep;
  assign error_output_settings = s_q.settings;
endmodule : error_flag_ctrl

// >>> core/rxerr_cfg.svh
`ifndef RXERR_CFG_SVH
`define RXERR_CFG_SVH
`define SER_DEV_ADDR    8'hE8
`define SER_CMD_ERR     4'h9
`define SET_RESET       8'h00
`define SET_USED_MASK   8'hF3
`define SET_SEL_BIT     0
`define SET_PAR_BIT     1
`define SET_FORCE_BIT   4
`define SET_MASK_BIT    5
`define SET_WAIT_LO     6
`define WAIT_CODE0      5'h03
`define WAIT_CODE1      5'h18
`define WAIT_CODE2      5'h0C
`define WAIT_CODE3      5'h1F
`define PAR_RUN         4'h8
`define CLK_HZ          125000000
`define GP_TICK_HZ      24000
`define GP_DIV_CYCLES   (`CLK_HZ / `GP_TICK_HZ)
`endif

// >>> core/rxerr_pkg.sv
package rxerr_pkg;
  typedef enum logic [0:0] {
    PH_ADDR = 1'b0,
    PH_DATA = 1'b1
  } ser_phase_type;

  typedef struct packed {
    ser_phase_type phase;
    logic          ce;
    logic          clk;
    logic [7:0]    addr;
    logic [15:0]   data;
    logic [4:0]    nbits;
    logic [7:0]    settings;
    logic [47:0]   cs_prev;
    logic [15:0]   pc_prev;
    logic [3:0]    gp_prev;
    logic [12:0]   gp_div;
    logic [3:0]    par_run;
    logic          err_pin;
    logic          audio_en;
    logic          mute;
    logic          cs_upd;
    logic          pc_upd;
    logic          gp_upd;
    logic          detect_rep;
  } ctrl_state_type;

  typedef struct packed {
    logic [4:0] cnt;
    logic       done;
  } cnt_state_type;
endpackage : rxerr_pkg

// >>> core/wait_if.sv
`timescale 1ns/10ps
interface wait_if;
  logic       clear;
  logic       tick;
  logic [4:0] target;
  logic       done;
  modport ctl (output clear, output tick, output target, input done);
  modport cnt (input clear, input tick, input target, output done);
endinterface : wait_if

// >>> core/preamble_counter.sv
`timescale 1ns/10ps
module preamble_counter (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Wait control
  wait_if.cnt      w
);
  rxerr_pkg::cnt_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (w.clear) begin
      s_d = '0;
    end else if (w.tick && !s_q.done) begin
      s_d.cnt = s_q.cnt + 5'h01;
      if (s_d.cnt >= w.target) begin
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign w.done = s_q.done;
endmodule : preamble_counter

// >>> tb/error_flag_ctrl_assertions.sv
`timescale 1ns/10ps
module error_flag_ctrl_checker (
  // Clock and reset
  input logic       mclk,
  input logic       rst_b,
  // Receiver status
  input logic       pll_locked,
  input logic       non_pcm_detected,
  input logic       rate_change_meas,
  input logic       osc_stopped,
  input logic       block_valid,
  input logic       input_change,
  input logic       input_monitor_en,
  // Outputs
  input logic       error_flag_pin,
  input logic       audio_out_en,
  input logic       audio_mute,
  input logic       pc_updated,
  input logic       input_detect_report,
  input logic [7:0] error_output_settings
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  force_pin_a: assert property (error_output_settings[4] |=> error_flag_pin)
    else $error("forced pin low");
  unlock_pin_a: assert property (!pll_locked |=> error_flag_pin)
    else $error("pin low while unlocked");
  wait_hold_a: assert property ($rose(pll_locked) |-> error_flag_pin [*3])
    else $error("wait too short");
  audio_start_a: assert property ($rose(audio_out_en) &&
    !$past(error_output_settings[4]) |-> !error_flag_pin)
    else $error("audio before release");
  npcm_mute_a: assert property (error_output_settings[0] && non_pcm_detected |=> audio_mute)
    else $error("no mute");
  rate_err_a: assert property (!error_output_settings[5] && rate_change_meas &&
    !osc_stopped |=> error_flag_pin)
    else $error("rate change missed");
  pc_cause_a: assert property (pc_updated |-> $past(block_valid))
    else $error("stray pc flag");
  detect_gate_a: assert property (input_detect_report |->
    $past(input_change && input_monitor_en))
    else $error("stray report");
  cover property (pc_updated);
  cover property (audio_mute);
  cover property ($fell(error_flag_pin));
endmodule : error_flag_ctrl_checker
bind error_flag_ctrl error_flag_ctrl_checker chk_u (.*);

// >>> tb/host_port_model.sv
`timescale 1ns/10ps
module host_port_model (
  // Clock
  input  logic mclk,
  // Serial port
  output logic ser_clk,
  output logic ser_data,
  output logic ser_enable
);
  initial {ser_clk, ser_data, ser_enable} = 3'h0;
  task automatic send(input logic [7:0] a, input logic [15:0] d);
    integer i;
    for (i = 0; i < 24; i++) begin
      ser_enable <= (i > 7);
      ser_data <= (i < 8) ? a[i] : d[i - 8];
      repeat (2) @(posedge mclk);
      ser_clk <= 1'h1;
      repeat (2) @(posedge mclk);
      ser_clk <= 1'h0;
    end
    repeat (2) @(posedge mclk);
    ser_enable <= 1'h0;
    ser_data <= ~ser_data;
    repeat (2) @(posedge mclk);
  endtask : send
endmodule : host_port_model

// >>> tb/test_receiver_error_flag_control.sv
`timescale 1ns/10ps
module test_receiver_error_flag_control;
  logic mclk = 0, rst_b = 0, ser_clk, ser_data, ser_enable, pll_locked = 0, block_start = 0;
  logic subframe_strobe = 0, parity_error = 0, non_pcm_detected = 0, rate_change_meas = 0;
  logic rate_change_cs = 0, osc_stopped = 0, block_valid = 0, gp_parallel_in_mode = 0;
  logic input_change = 0, input_detect_report_en = 0, crystal_input_select = 0;
  logic crystal_24m576_present = 0, input_monitor_en = 0;
  logic [47:0] cs_bits = 0, c, pc = 0;
  logic [15:0] burst_pc = 0, p, pp = 0;
  logic [3:0]  gp_in = 0;
  logic        error_flag_pin, audio_out_en, audio_mute, cs_updated, pc_updated, gp_updated;
  logic        input_detect_report;
  logic [7:0]  error_output_settings, exp_set = 0;
  int          waits [$] = '{3, 24, 12, 31};
  logic [4:0]  rates [4] = '{5'h16, 5'hC, 5'hB, 5'h5};
  integer      fail_count = 0, n_compared = 0, seed = 32'h5CEEDC82, k, n;
  error_flag_ctrl #(.GP_DIV(4)) dut_u (.*);
  host_port_model hp_u (.*);
  always #4 mclk = ~mclk;
  task automatic cyc(input integer m);
    repeat (m) @(posedge mclk);
  endtask : cyc
  task automatic chk(input logic [47:0] seen, input logic [47:0] want);
    n_compared++;
    if (seen !== want) begin
      fail_count++;
      $display("Error at %0t: got %0h want %0h", $time, seen, want);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] s, input logic [7:0] cmd);
    hp_u.send(a, {s, cmd});
    if (a == 8'hE8 && cmd == 8'h90) exp_set = s & 8'hF3;
    cyc(2);
    chk(error_output_settings, exp_set);
  endtask : wr
  task automatic lock(input integer w);
    pll_locked <= 0;
    cyc(3);
    pll_locked <= 1;
    for (k = 0; k < w; k++) begin
      cyc(2);
      chk(error_flag_pin, 1'h1);
      block_start <= 1;
      cyc(1);
      block_start <= 0;
    end
    cyc(1);
    chk(error_flag_pin, 1'h1);
    cyc(1);
    chk(error_flag_pin, 1'h0);
    chk(audio_out_en, 1'h1);
  endtask : lock
  task final_report;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  initial begin
    cyc(5);
    chk(error_output_settings, 8'h00);
    rst_b <= 1;
    wr(8'hE8, 8'hFF, 8'h90);
    wr(8'hE9, 8'h00, 8'h90);
    wr(8'hE8, 8'h00, 8'h80);
    for (n = 0; n < 4; n++) begin
      wr(8'hE8, {n[1:0], 6'h00}, 8'h90);
      lock(waits[n]);
    end
    wr(8'hE8, 8'h10, 8'h90);
    chk(error_flag_pin, 1'h1);
    chk(audio_out_en, 1'h1);
    for (n = 0; n < 2; n++) begin
      wr(8'hE8, n[7:0], 8'h90);
      lock(3);
      non_pcm_detected <= 1;
      cyc(3);
      chk(audio_mute, n[0]);
      chk(error_flag_pin, n[0]);
      non_pcm_detected <= 0;
    end
    for (n = 0; n < 4; n++) begin
      wr(8'hE8, {2'h0, rates[n][4], 5'h00}, 8'h90);
      lock(3);
      {osc_stopped, rate_change_meas, rate_change_cs} <= rates[n][3:1];
      cyc(3);
      chk(error_flag_pin, rates[n][0]);
      {osc_stopped, rate_change_meas, rate_change_cs} <= 3'h0;
    end
    wr(8'hE8, 8'h02, 8'h90);
    lock(3);
    {subframe_strobe, parity_error} <= 2'h3;
    cyc(1);
    {subframe_strobe, parity_error} <= 2'h0;
    cyc(1);
    chk(error_flag_pin, 1'h1);
    cyc(1);
    chk(error_flag_pin, 1'h0);
    wr(8'hE8, 8'h00, 8'h90);
    non_pcm_detected <= 1;
    cyc(3);
    chk(error_flag_pin, 1'h1);
    subframe_strobe <= 1;
    cyc(8);
    subframe_strobe <= 0;
    cyc(3);
    chk(error_flag_pin, 1'h0);
    non_pcm_detected <= 0;
    for (n = 0; n < 6; n++) begin
      c = n[0] ? c : 48'({$random(seed), $random(seed)});
      p = n[0] ? p : 16'($random(seed));
      cs_bits <= c;
      burst_pc <= p;
      block_valid <= 1;
      cyc(1);
      block_valid <= 0;
      cyc(1);
      chk(cs_updated, c == pc);
      chk(pc_updated, p == pp);
      pc = c;
      pp = p;
    end
    gp_parallel_in_mode <= 1;
    for (n = 0; n < 3; n++) begin
      gp_in <= n ? 4'h4 : 4'h5;
      k = 0;
      repeat (40) begin
        cyc(1);
        k += gp_updated;
      end
      chk(48'(k), n < 2);
    end
    for (n = 0; n < 5; n++) begin
      {input_detect_report_en, crystal_input_select, crystal_24m576_present,
       input_monitor_en} <= 4'hF & ~(4'h1 << n);
      input_change <= 1;
      cyc(1);
      input_change <= 0;
      cyc(1);
      chk(input_detect_report, n == 4);
    end
    final_report;
  end
endmodule : test_receiver_error_flag_control
